// *** bench/cbcs_mem_model.sv ***
/*
 * cbcs_mem_model: behavioural memory and peripheral space on the system bus.
 * Assumes a synchronous bus: read data answers ADDR in the same CLK cycle.
 */
`timescale 1ns/1ps
module cbcs_mem_model (
	// clock
	input wire logic clk,
	// bus from the sequencer
	input wire logic [15:0] addr,
	input wire logic rw,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	// read data back
	output logic [7:0] data_in
);
	// ==========================================================
	// storage
	logic [7:0] mem [0:65535];
	logic [7:0] last_reg;

	// fill every byte with an address pattern so no read is left unknown
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5A;
		end
		last_reg = 8'h00;
	end

	// ==========================================================
	// read path: a write cycle leaves the line showing the inverse of the last level
	always_comb begin
		if (rw) begin
			data_in = mem[addr];
		end else begin
			data_in = ~last_reg;
		end
	end

	// store written bytes and remember the last level on the line
	always @(posedge clk) begin
		last_reg <= data_in;
		if (!rw && !data_oe_n) begin
			mem[addr] <= data_out;
		end
	end
endmodule

// *** bench/cpu_bus_cycle_sequencer_tb.sv ***
/*
 * cpu_bus_cycle_sequencer_tb: self-checking bench of the bus cycle sequencer.
 * Assumes the memory model answers reads in the same cycle and the package encoding.
 */
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_tb;
	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic start = 1'b0;
	logic [15:0] op_addr = 16'h0000;
	logic [7:0] acca = 8'h00;
	logic [15:0] accd = 16'h0000;
	logic [15:0] ix = 16'h0000;
	logic [15:0] sp = 16'h0000;
	logic [15:0] addr;
	logic rw;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic data_oe_n;
	logic busy;
	logic done;
	logic illegal;
	logic [7:0] opcode;
	logic [15:0] result;
	int error_cnt = 0;
	int comparisons = 0;
	logic [24:0] exp_q [$];
	logic [15:0] exp_res;
	logic exp_ill;
	logic chk_res;
	int unsigned seed_val;

	// 250 MHz cycle clock
	always #2 clk = ~clk;

	// ==========================================================
	// design and far side
	cbcs_sequencer u_dut (
		.CLK(clk), .SYS_RST(sys_rst), .START(start), .OP_ADDR(op_addr),
		.ACCA_VAL(acca), .ACCD_VAL(accd), .IX_VAL(ix), .SP_VAL(sp),
		.ADDR(addr), .RW(rw), .DATA_IN(data_in), .DATA_OUT(data_out),
		.DATA_OE_N(data_oe_n), .BUSY(busy), .DONE(done), .ILLEGAL(illegal),
		.OPCODE(opcode), .RESULT(result)
	);
	cbcs_mem_model u_mem (
		.clk(clk), .addr(addr), .rw(rw), .data_out(data_out),
		.data_oe_n(data_oe_n), .data_in(data_in)
	);

	// ==========================================================
	// reporting
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ==========================================================
	// expectation builder: one entry per bus cycle {address, rw, write data}
	task automatic push(input logic [15:0] a, input logic r, input logic [7:0] d);
		exp_q.push_back({a, r, d});
	endtask

	task automatic build(input logic [7:0] op, input logic [15:0] pa);
		logic [7:0] d1;
		logic [15:0] ea;
		logic [15:0] rv;
		logic [15:0] ret;
		d1 = u_mem.mem[pa + 16'h0001];
		ea = {cbcs_pkg::DIRECT_PAGE, d1};
		rv = (op[3:0] == 4'hC) ? sp : (op[3:0] == 4'hD) ? ix : accd;
		ret = pa + 16'h0002;
		exp_q = {};
		exp_ill = 1'b0;
		chk_res = 1'b1;
		push(pa, 1'b1, 8'h00);
		if (op[7:4] == 4'h8 && op[3:0] <= 4'h4) begin
			push(pa + 16'h0001, 1'b1, 8'h00);
			exp_res = {8'h00, d1};
		end else if (op[7:4] == 4'h8 && op[3:0] <= 4'h7) begin
			push(pa + 16'h0001, 1'b1, 8'h00);
			push(pa + 16'h0002, 1'b1, 8'h00);
			exp_res = {d1, u_mem.mem[pa + 16'h0002]};
		end else if (op[7:4] == 4'h8 && op[3:0] <= 4'hA) begin
			push(pa + 16'h0001, 1'b1, 8'h00);
			push(pa + 16'h0002, 1'b1, 8'h00);
			push(16'hFFFF, 1'b1, 8'h00);
			exp_res = {d1, u_mem.mem[pa + 16'h0002]};
		end else if (op[7:4] == 4'h9) begin
			push(pa + 16'h0001, 1'b1, 8'h00);
			if (op[3:0] <= 4'h4) begin
				push(ea, 1'b1, 8'h00);
				exp_res = {8'h00, u_mem.mem[ea]};
			end else if (op[3:0] <= 4'h7) begin
				push(ea, 1'b1, 8'h00);
				push(ea + 16'h0001, 1'b1, 8'h00);
				exp_res = {u_mem.mem[ea], u_mem.mem[ea + 16'h0001]};
			end else if (op[3:0] <= 4'hA) begin
				push(ea, 1'b1, 8'h00);
				push(ea + 16'h0001, 1'b1, 8'h00);
				push(16'hFFFF, 1'b1, 8'h00);
				exp_res = {u_mem.mem[ea], u_mem.mem[ea + 16'h0001]};
			end else if (op[3:0] == 4'hB) begin
				push(ea, 1'b0, acca);
				chk_res = 1'b0;
			end else if (op[3:0] <= 4'hE) begin
				push(ea, 1'b0, rv[15:8]);
				push(ea + 16'h0001, 1'b0, rv[7:0]);
				chk_res = 1'b0;
			end else begin
				push(ea, 1'b1, 8'h00);
				push(sp, 1'b0, ret[7:0]);
				push(sp + 16'h0001, 1'b0, ret[15:8]);
				chk_res = 1'b0;
			end
		end else begin
			exp_ill = 1'b1;
			chk_res = 1'b0;
		end
	endtask

	// ==========================================================
	// one instruction; hold keeps START up while busy with a changed address
	task automatic run(input logic [7:0] op, input logic [15:0] pa, input logic [7:0] d1,
			input logic [15:0] spv, input bit hold);
		logic [15:0] ea;
		ea = {8'h00, d1};
		u_mem.mem[pa] = op;
		u_mem.mem[pa + 16'h0001] = d1;
		u_mem.mem[pa + 16'h0002] = 8'($urandom);
		u_mem.mem[ea] = 8'($urandom);
		u_mem.mem[ea + 16'h0001] = 8'($urandom);
		acca = 8'($urandom);
		accd = 16'($urandom);
		ix = 16'($urandom);
		sp = spv;
		build(op, pa);
		start = 1'b1;
		op_addr = pa;
		@(posedge clk);
		#1;
		if (hold) begin
			op_addr = ~pa;
		end else begin
			start = 1'b0;
		end
		for (int k = 0; k < exp_q.size(); k++) begin
			check(addr, exp_q[k][24:9]);
			check({15'h0000, rw}, {15'h0000, exp_q[k][8]});
			check({8'h00, data_out}, {8'h00, exp_q[k][7:0]});
			check({15'h0000, data_oe_n}, {15'h0000, exp_q[k][8]});
			check({14'h0000, busy, done}, 16'h0002);
			if (hold && k == exp_q.size() - 1) begin
				start = 1'b0;
			end
			@(posedge clk);
			#1;
		end
		check({14'h0000, busy, done}, 16'h0001);
		check({15'h0000, illegal}, {15'h0000, exp_ill});
		check({8'h00, opcode}, {8'h00, op});
		if (chk_res) begin
			check(result, exp_res);
		end
	endtask

	// idle and reset levels of the bus and status outputs
	task automatic check_idle();
		check(addr, 16'hFFFF);
		check({12'h000, rw, data_oe_n, busy, done}, 16'h000C);
		check({8'h00, data_out}, 16'h0000);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		logic [7:0] op;
		seed_val = $urandom(32'h0A57A61C);
		repeat (20) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		check_idle();
		// every operation code of both modes, back to back
		for (int n = 0; n < 32; n++) begin
			op = {(n < 16) ? 4'h8 : 4'h9, 4'(n)};
			run(op, 16'h1000 + 16'($urandom % 32'hE000), 8'($urandom), 16'($urandom), 1'b0);
		end
		// corner cases: direct page crossing, stack wrap, start held while busy, unknown code
		run(8'h95, 16'h1234, 8'hFF, 16'h0000, 1'b0);
		run(8'h9C, 16'hEFFD, 8'hFF, 16'h0000, 1'b0);
		run(8'h9F, 16'h20FE, 8'h80, 16'hFFFF, 1'b0);
		run(8'h98, 16'h3000, 8'h10, 16'h0400, 1'b1);
		run(8'h3C, 16'h4000, 8'h00, 16'h0400, 1'b1);
		// reset in the middle of a call
		u_mem.mem[16'h2000] = 8'h9F;
		start = 1'b1;
		op_addr = 16'h2000;
		@(posedge clk);
		#1;
		start = 1'b0;
		@(posedge clk);
		#1;
		sys_rst = 1'b1;
		@(posedge clk);
		#1;
		sys_rst = 1'b0;
		check_idle();
		check({8'h00, opcode}, 16'h0000);
		check(result, 16'h0000);
		// random traffic, with fully random codes now and then
		for (int n = 0; n < 300; n++) begin
			op = ($urandom % 8 == 0) ? 8'($urandom) : {4'h8 + 4'($urandom % 2), 4'($urandom)};
			run(op, 16'h1000 + 16'($urandom % 32'hE000), 8'($urandom), 16'($urandom),
				1'($urandom % 4 == 0));
		end
		wrap_up();
	end

	// watchdog against a stuck run
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
endmodule

// *** core/cbcs_addr_gen.sv ***
/*
 * cbcs_addr_gen: forms the bus address of a cycle from its address select.
 * Assumes base addresses are stable in the cycle they are used; sums wrap.
 */
`timescale 1ns/1ps
module cbcs_addr_gen (
	// address sources
	input wire cbcs_pkg::cbcs_asel_type asel,
	input wire logic [15:0] opaddr,
	input wire logic [15:0] eaddr,
	input wire logic [15:0] spv,
	// formed address
	output logic [15:0] addr
);

	// ==========================================================
	// address mux with wrapping increments
	always_comb begin
		case (asel)
			cbcs_pkg::AS_OPA: addr = opaddr;
			cbcs_pkg::AS_OP1: addr = 16'(opaddr + cbcs_pkg::ADDR_INC1);
			cbcs_pkg::AS_OP2: addr = 16'(opaddr + cbcs_pkg::ADDR_INC2);
			cbcs_pkg::AS_EA: addr = eaddr;
			cbcs_pkg::AS_EA1: addr = 16'(eaddr + cbcs_pkg::ADDR_INC1);
			cbcs_pkg::AS_SP: addr = spv;
			cbcs_pkg::AS_SP1: addr = 16'(spv + cbcs_pkg::ADDR_INC1);
			default: addr = cbcs_pkg::VEC_ADDR;
		endcase
	end

endmodule

// *** core/cbcs_decode.sv ***
/*
 * cbcs_decode: maps a fetched opcode to its sequence class and register.
 * Assumes the opcode layout held in cbcs_pkg; unknown codes give CLS_NONE.
 */
`timescale 1ns/1ps
module cbcs_decode (
	// opcode in
	input wire logic [7:0] opcode,
	// decoded class
	output cbcs_pkg::cbcs_cls_type cls,
	output cbcs_pkg::cbcs_rsel_type rsel
);

	// ==========================================================
	// class and register decode
	always_comb begin
		cls = cbcs_pkg::CLS_NONE;
		rsel = cbcs_pkg::RS_A;
		case (opcode[3:0])
			cbcs_pkg::OPX_LOAD_SP, cbcs_pkg::OPX_STORE_SP: rsel = cbcs_pkg::RS_SP;
			cbcs_pkg::OPX_LOAD_IX, cbcs_pkg::OPX_STORE_IX: rsel = cbcs_pkg::RS_IX;
			cbcs_pkg::OPX_LOAD_D, cbcs_pkg::OPX_STORE_D: rsel = cbcs_pkg::RS_D;
			default: rsel = cbcs_pkg::RS_A;
		endcase
		if (opcode[7:4] == cbcs_pkg::MODE_IMM) begin
			if (opcode[3:0] <= cbcs_pkg::OPX_COMPARE_ACC) begin
				cls = cbcs_pkg::CLS_IMM8;
			end else if (opcode[3:0] <= cbcs_pkg::OPX_LOAD_D) begin
				cls = cbcs_pkg::CLS_IMM16_LOAD;
			end else if (opcode[3:0] <= cbcs_pkg::OPX_ADD_D) begin
				cls = cbcs_pkg::CLS_IMM16_ARITH;
			end
		end else if (opcode[7:4] == cbcs_pkg::MODE_DIR) begin
			if (opcode[3:0] <= cbcs_pkg::OPX_COMPARE_ACC) begin
				cls = cbcs_pkg::CLS_DIR8_READ;
			end else if (opcode[3:0] <= cbcs_pkg::OPX_LOAD_D) begin
				cls = cbcs_pkg::CLS_DIR16_LOAD;
			end else if (opcode[3:0] <= cbcs_pkg::OPX_ADD_D) begin
				cls = cbcs_pkg::CLS_DIR16_ARITH;
			end else if (opcode[3:0] == cbcs_pkg::OPX_STORE_ACC) begin
				cls = cbcs_pkg::CLS_DIR8_STORE;
			end else if (opcode[3:0] == cbcs_pkg::OPX_CALL) begin
				cls = cbcs_pkg::CLS_CALL;
			end else begin
				cls = cbcs_pkg::CLS_DIR16_STORE;
			end
		end
	end

endmodule

// *** core/cbcs_sequencer.sv ***
/*
 * cbcs_sequencer: bus cycle sequencer for immediate and direct instructions.
 * Assumes memory answers DATA_IN in the same CLK cycle as ADDR (synchronous bus),
 * and the register value inputs are stable from START until DONE.
 */
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - every cycle drives defined address, direction, data
// RULE2 - one sequence per mode and cycle count
// RULE3 - immediate 16-bit loads: opcode, high, low
// RULE4 - immediate 16-bit arithmetic adds dummy FFFF read
// RULE5 - direct 16-bit arithmetic: five reads, dummy last
// RULE6 - direct 16-bit loads: four reads, high then low
// RULE7 - direct 16-bit store writes high byte third
// RULE8 - direct 16-bit store writes low byte fourth
// RULE9 - call: address byte read, then irrelevant read at the subroutine address
// RULE10 - call cycle four writes return low byte
// RULE11 - call cycle five writes return high byte
// RULE12 - immediate 8-bit: opcode then operand read
// RULE13 - direct 8-bit: operand read or accumulator write
module cbcs_sequencer (
	// clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// instruction start
	input wire logic START,
	input wire logic [15:0] OP_ADDR,
	// cpu register values
	input wire logic [7:0] ACCA_VAL,
	input wire logic [15:0] ACCD_VAL,
	input wire logic [15:0] IX_VAL,
	input wire logic [15:0] SP_VAL,
	// system bus
	output logic [15:0] ADDR,
	output logic RW,
	input wire logic [7:0] DATA_IN,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE_N,
	// status
	output logic BUSY,
	output logic DONE,
	output logic ILLEGAL,
	output logic [7:0] OPCODE,
	output logic [15:0] RESULT
);

	typedef struct packed {
		cbcs_pkg::cbcs_step_type step;
		cbcs_pkg::cbcs_cls_type cls;
		cbcs_pkg::cbcs_rsel_type rsel;
		logic [15:0] opaddr;
		logic [15:0] eaddr;
		logic [15:0] spv;
		logic [15:0] sval;
		logic [15:0] result;
		logic [7:0] opcode;
		logic [15:0] addr;
		logic rw;
		logic [7:0] dout;
		logic oe_n;
		logic done;
		logic illegal;
	} cbcs_state_type;

	cbcs_state_type state_reg;
	cbcs_state_type state_next;
	cbcs_pkg::cbcs_cls_type dec_cls;
	cbcs_pkg::cbcs_rsel_type dec_rsel;
	cbcs_pkg::cbcs_plan_type cur_plan;
	cbcs_pkg::cbcs_plan_type nxt_plan;
	cbcs_pkg::cbcs_cls_type cur_cls;
	logic [15:0] nxt_addr;

	// ==========================================================
	// sequence table: bus cycle for a class and step
	function automatic cbcs_pkg::cbcs_plan_type plan_of(input cbcs_pkg::cbcs_cls_type cls,
			input cbcs_pkg::cbcs_step_type step);
		cbcs_pkg::cbcs_plan_type p;
		p = '{cbcs_pkg::AS_VEC, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_NONE, 1'b1};
		case (step)
			cbcs_pkg::ST_C1: begin
				p = '{cbcs_pkg::AS_OPA, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_OPC,
					cls == cbcs_pkg::CLS_NONE};
			end
			cbcs_pkg::ST_C2: begin
				case (cls)
					cbcs_pkg::CLS_IMM8: p.cap = cbcs_pkg::CAP_LO8; // see RULE12
					cbcs_pkg::CLS_IMM16_LOAD, cbcs_pkg::CLS_IMM16_ARITH: p.cap = cbcs_pkg::CAP_HI;
					default: p.cap = cbcs_pkg::CAP_EA; // see RULE9
				endcase
				p.asel = cbcs_pkg::AS_OP1;
				p.last = (cls == cbcs_pkg::CLS_IMM8);
			end
			cbcs_pkg::ST_C3: begin
				case (cls)
					cbcs_pkg::CLS_IMM16_LOAD: begin // see RULE3
						p = '{cbcs_pkg::AS_OP2, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_LO, 1'b1};
					end
					cbcs_pkg::CLS_IMM16_ARITH: begin // see RULE4
						p = '{cbcs_pkg::AS_OP2, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_LO, 1'b0};
					end
					cbcs_pkg::CLS_DIR8_READ: begin // see RULE13
						p = '{cbcs_pkg::AS_EA, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_LO8, 1'b1};
					end
					cbcs_pkg::CLS_DIR8_STORE: begin // see RULE13
						p = '{cbcs_pkg::AS_EA, 1'b0, cbcs_pkg::DS_ACCA, cbcs_pkg::CAP_NONE, 1'b1};
					end
					cbcs_pkg::CLS_DIR16_STORE: begin // see RULE7
						p = '{cbcs_pkg::AS_EA, 1'b0, cbcs_pkg::DS_REGHI, cbcs_pkg::CAP_NONE, 1'b0};
					end
					cbcs_pkg::CLS_CALL: begin // see RULE9
						p = '{cbcs_pkg::AS_EA, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_NONE, 1'b0};
					end
					default: begin // see RULE5, RULE6
						p = '{cbcs_pkg::AS_EA, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_HI, 1'b0};
					end
				endcase
			end
			cbcs_pkg::ST_C4: begin
				case (cls)
					cbcs_pkg::CLS_DIR16_LOAD: begin // see RULE6
						p = '{cbcs_pkg::AS_EA1, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_LO, 1'b1};
					end
					cbcs_pkg::CLS_DIR16_STORE: begin // see RULE8
						p = '{cbcs_pkg::AS_EA1, 1'b0, cbcs_pkg::DS_REGLO, cbcs_pkg::CAP_NONE, 1'b1};
					end
					cbcs_pkg::CLS_DIR16_ARITH: begin // see RULE5
						p = '{cbcs_pkg::AS_EA1, 1'b1, cbcs_pkg::DS_NONE, cbcs_pkg::CAP_LO, 1'b0};
					end
					cbcs_pkg::CLS_CALL: begin // see RULE10
						p = '{cbcs_pkg::AS_SP, 1'b0, cbcs_pkg::DS_RETLO, cbcs_pkg::CAP_NONE, 1'b0};
					end
					default: p.last = 1'b1; // see RULE4
				endcase
			end
			cbcs_pkg::ST_C5: begin
				if (cls == cbcs_pkg::CLS_CALL) begin // see RULE11
					p = '{cbcs_pkg::AS_SP1, 1'b0, cbcs_pkg::DS_RETHI, cbcs_pkg::CAP_NONE, 1'b1};
				end
			end
			default: p.last = 1'b1;
		endcase
		return p;
	endfunction

	// ==========================================================
	// submodules
	cbcs_decode u_decode (
		.opcode(DATA_IN),
		.cls(dec_cls),
		.rsel(dec_rsel)
	);

	cbcs_addr_gen u_addr_gen (
		.asel(nxt_plan.asel),
		.opaddr(state_next.opaddr),
		.eaddr(state_next.eaddr),
		.spv(state_next.spv),
		.addr(nxt_addr)
	);

	// ==========================================================
	// step transition, captures and next bus cycle
	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		state_next.illegal = 1'b0;
		cur_cls = (state_reg.step == cbcs_pkg::ST_C1) ? dec_cls : state_reg.cls;
		cur_plan = plan_of(cur_cls, state_reg.step);
		if (state_reg.step == cbcs_pkg::ST_IDLE) begin
			if (START) begin
				state_next.step = cbcs_pkg::ST_C1;
				state_next.opaddr = OP_ADDR;
			end
		end else begin
			// capture what the finished read cycle returned
			case (cur_plan.cap)
				cbcs_pkg::CAP_OPC: begin
					state_next.opcode = DATA_IN;
					state_next.cls = dec_cls;
					state_next.rsel = dec_rsel;
					state_next.illegal = (dec_cls == cbcs_pkg::CLS_NONE);
				end
				cbcs_pkg::CAP_EA: state_next.eaddr = {cbcs_pkg::DIRECT_PAGE, DATA_IN};
				cbcs_pkg::CAP_HI: state_next.result[15:8] = DATA_IN;
				cbcs_pkg::CAP_LO: state_next.result[7:0] = DATA_IN;
				cbcs_pkg::CAP_LO8: state_next.result = {cbcs_pkg::BYTE_ZERO, DATA_IN};
				default: state_next.result = state_reg.result;
			endcase
			// latch store data and stack pointer once per instruction
			if (state_reg.step == cbcs_pkg::ST_C2) begin
				state_next.spv = SP_VAL;
				case (state_reg.rsel)
					cbcs_pkg::RS_SP: state_next.sval = SP_VAL;
					cbcs_pkg::RS_IX: state_next.sval = IX_VAL;
					cbcs_pkg::RS_D: state_next.sval = ACCD_VAL;
					default: state_next.sval = {cbcs_pkg::BYTE_ZERO, ACCA_VAL};
				endcase
			end
			if (cur_plan.last) begin
				state_next.step = cbcs_pkg::ST_IDLE;
				state_next.done = 1'b1;
			end else begin
				state_next.step = cbcs_pkg::cbcs_step_type'(state_reg.step + 3'b001);
			end
		end
		// drive the bus for the step being entered, see RULE1, RULE2
		nxt_plan = plan_of(state_next.cls, state_next.step);
		state_next.addr = nxt_addr;
		state_next.rw = nxt_plan.rw;
		state_next.oe_n = nxt_plan.rw;
		case (nxt_plan.dsel)
			cbcs_pkg::DS_ACCA: state_next.dout = state_next.sval[7:0];
			cbcs_pkg::DS_REGHI: state_next.dout = state_next.sval[15:8];
			cbcs_pkg::DS_REGLO: state_next.dout = state_next.sval[7:0];
			cbcs_pkg::DS_RETLO: state_next.dout = 8'(state_next.opaddr + cbcs_pkg::ADDR_INC2);
			cbcs_pkg::DS_RETHI: begin
				state_next.dout = 8'((state_next.opaddr + cbcs_pkg::ADDR_INC2) >> 8);
			end
			default: state_next.dout = cbcs_pkg::BYTE_ZERO;
		endcase
	end

	// ==========================================================
	// state register
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_reg <= '{cbcs_pkg::ST_IDLE, cbcs_pkg::CLS_NONE, cbcs_pkg::RS_A, 16'h0000,
				16'h0000, 16'h0000, 16'h0000, 16'h0000, 8'h00, cbcs_pkg::VEC_ADDR, 1'b1,
				8'h00, 1'b1, 1'b0, 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign ADDR = state_reg.addr;
	assign RW = state_reg.rw;
	assign DATA_OUT = state_reg.dout;
	assign DATA_OE_N = state_reg.oe_n;
	assign BUSY = (state_reg.step != cbcs_pkg::ST_IDLE);
	assign DONE = state_reg.done;
	assign ILLEGAL = state_reg.illegal;
	assign OPCODE = state_reg.opcode;
	assign RESULT = state_reg.result;

	// ==========================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	wire logic [15:0] op1_w = 16'(state_reg.opaddr + cbcs_pkg::ADDR_INC1);
	wire logic [15:0] op2_w = 16'(state_reg.opaddr + cbcs_pkg::ADDR_INC2);
	wire logic [15:0] ea1_w = 16'(state_reg.eaddr + cbcs_pkg::ADDR_INC1);
	wire logic [15:0] sp1_w = 16'(SP_VAL + cbcs_pkg::ADDR_INC1);
	// store source picked from the opcode, independent of the latched copy
	wire logic [15:0] st_w = (OPCODE[3:0] == cbcs_pkg::OPX_STORE_SP) ? SP_VAL
		: (OPCODE[3:0] == cbcs_pkg::OPX_STORE_IX) ? IX_VAL : ACCD_VAL;
	wire logic is_c2 = (state_reg.step == cbcs_pkg::ST_C2);
	wire logic is_c3 = (state_reg.step == cbcs_pkg::ST_C3);

	sequence dummy_s;
		ADDR == cbcs_pkg::VEC_ADDR && RW;
	endsequence
	sequence end_s;
		DONE && !BUSY;
	endsequence
	sequence rd_s(logic [15:0] a);
		ADDR == a && RW && DATA_OE_N;
	endsequence

	opcode_fetch_a: assert property (START && !BUSY |=> ADDR == $past(OP_ADDR) && RW // see RULE1
		&& state_reg.step == cbcs_pkg::ST_C1) else $error("opcode fetch not presented");
	drive_dir_a: assert property (DATA_OE_N == RW // see RULE1
		&& (!RW || DATA_OUT == cbcs_pkg::BYTE_ZERO))
		else $error("data drive does not follow direction");
	imm8_seq_a: assert property (is_c2 && state_reg.cls == cbcs_pkg::CLS_IMM8 // see RULE12
		|-> rd_s(op1_w) ##1 end_s) else $error("immediate byte sequence wrong");
	imm16_load_a: assert property (is_c2 && state_reg.cls == cbcs_pkg::CLS_IMM16_LOAD // see RULE3
		|-> rd_s(op1_w) ##1 rd_s(op2_w) ##1 end_s) else $error("immediate load wrong");
	imm16_arith_a: assert property (is_c2 && state_reg.cls == cbcs_pkg::CLS_IMM16_ARITH // see RULE4
		|-> rd_s(op1_w) ##1 rd_s(op2_w) ##1 dummy_s ##1 end_s)
		else $error("immediate arithmetic sequence wrong");
	dir8_seq_a: assert property (is_c3 && state_reg.cls == cbcs_pkg::CLS_DIR8_STORE // see RULE13
		|-> ADDR == state_reg.eaddr && !RW && DATA_OUT == ACCA_VAL ##1 end_s)
		else $error("direct accumulator store wrong");
	dir16_load_a: assert property (is_c3 && state_reg.cls == cbcs_pkg::CLS_DIR16_LOAD // see RULE6
		|-> rd_s(state_reg.eaddr) ##1 rd_s(ea1_w) ##1 end_s) else $error("direct load wrong");
	dir16_store_a: assert property (is_c3 && state_reg.cls == cbcs_pkg::CLS_DIR16_STORE // see RULE7
		|-> ADDR == state_reg.eaddr && !RW && DATA_OUT == st_w[15:8]
		##1 ADDR == ea1_w && !RW && DATA_OUT == st_w[7:0] ##1 end_s) // see RULE8
		else $error("direct store wrong");
	dir16_arith_a: assert property (is_c3 && state_reg.cls == cbcs_pkg::CLS_DIR16_ARITH // see RULE5
		|-> rd_s(state_reg.eaddr) ##1 rd_s(ea1_w) ##1 dummy_s ##1 end_s)
		else $error("direct arithmetic sequence wrong");
	call_seq_a: assert property (is_c2 && state_reg.cls == cbcs_pkg::CLS_CALL // see RULE9
		|-> rd_s(op1_w) ##1 rd_s(state_reg.eaddr)
		##1 ADDR == SP_VAL && !RW && DATA_OUT == op2_w[7:0] // see RULE10
		##1 ADDR == sp1_w && !RW && DATA_OUT == op2_w[15:8] ##1 end_s) // see RULE11
		else $error("call sequence wrong");
	busy_bound_a: assert property ($rose(BUSY) |-> ##[1:5] DONE) // see RULE2
		else $error("instruction longer than five cycles");

endmodule

// *** pkg/cbcs_pkg.sv ***
/*
 * cbcs_pkg: constants and types shared by the bus cycle sequencer files.
 * Assumes one CPU cycle per CLK edge and a 16-bit address, 8-bit data bus.
 */
package cbcs_pkg;

	// ==========================================================
	// widths and fixed addresses
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] VEC_ADDR = 16'hFFFF; // dummy restart vector read address
	localparam logic [15:0] ADDR_INC1 = 16'h0001;
	localparam logic [15:0] ADDR_INC2 = 16'h0002;
	localparam logic [7:0] DIRECT_PAGE = 8'h00; // high byte of a direct address
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ==========================================================
	// opcode layout: high nibble is the mode, low nibble the operation (encoding arbitrary)
	localparam logic [3:0] MODE_IMM = 4'h8;
	localparam logic [3:0] MODE_DIR = 4'h9;
	localparam logic [3:0] OPX_EXCLUSIVE_OR = 4'h0;
	localparam logic [3:0] OPX_LOAD_ACC = 4'h1;
	localparam logic [3:0] OPX_BITWISE_OR = 4'h2;
	localparam logic [3:0] OPX_SUB_BORROW = 4'h3;
	localparam logic [3:0] OPX_COMPARE_ACC = 4'h4;
	localparam logic [3:0] OPX_LOAD_SP = 4'h5;
	localparam logic [3:0] OPX_LOAD_IX = 4'h6;
	localparam logic [3:0] OPX_LOAD_D = 4'h7;
	localparam logic [3:0] OPX_COMPARE_IX = 4'h8;
	localparam logic [3:0] OPX_SUB_D = 4'h9;
	localparam logic [3:0] OPX_ADD_D = 4'hA;
	localparam logic [3:0] OPX_STORE_ACC = 4'hB;
	localparam logic [3:0] OPX_STORE_SP = 4'hC;
	localparam logic [3:0] OPX_STORE_IX = 4'hD;
	localparam logic [3:0] OPX_STORE_D = 4'hE;
	localparam logic [3:0] OPX_CALL = 4'hF;

	// ==========================================================
	// instruction classes sharing one bus cycle sequence
	typedef enum logic [3:0] {
		CLS_NONE = 4'b0000,
		CLS_IMM8 = 4'b0001,
		CLS_IMM16_LOAD = 4'b0010,
		CLS_IMM16_ARITH = 4'b0011,
		CLS_DIR8_READ = 4'b0100,
		CLS_DIR8_STORE = 4'b0101,
		CLS_DIR16_LOAD = 4'b0110,
		CLS_DIR16_STORE = 4'b0111,
		CLS_DIR16_ARITH = 4'b1000,
		CLS_CALL = 4'b1001
	} cbcs_cls_type;

	typedef enum logic [1:0] {
		RS_SP = 2'b00,
		RS_IX = 2'b01,
		RS_D = 2'b10,
		RS_A = 2'b11
	} cbcs_rsel_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_C1 = 3'b001,
		ST_C2 = 3'b010,
		ST_C3 = 3'b011,
		ST_C4 = 3'b100,
		ST_C5 = 3'b101
	} cbcs_step_type;

	typedef enum logic [2:0] {
		AS_OPA = 3'b000,
		AS_OP1 = 3'b001,
		AS_OP2 = 3'b010,
		AS_EA = 3'b011,
		AS_EA1 = 3'b100,
		AS_VEC = 3'b101,
		AS_SP = 3'b110,
		AS_SP1 = 3'b111
	} cbcs_asel_type;

	typedef enum logic [2:0] {
		DS_NONE = 3'b000,
		DS_ACCA = 3'b001,
		DS_REGHI = 3'b010,
		DS_REGLO = 3'b011,
		DS_RETLO = 3'b100,
		DS_RETHI = 3'b101
	} cbcs_dsel_type;

	typedef enum logic [2:0] {
		CAP_NONE = 3'b000,
		CAP_OPC = 3'b001,
		CAP_EA = 3'b010,
		CAP_HI = 3'b011,
		CAP_LO = 3'b100,
		CAP_LO8 = 3'b101
	} cbcs_cap_type;

	// one bus cycle of a sequence
	typedef struct packed {
		cbcs_asel_type asel;
		logic rw;
		cbcs_dsel_type dsel;
		cbcs_cap_type cap;
		logic last;
	} cbcs_plan_type;

endpackage
